//--- hw/rslc_ctrl.sv
/*
  Per-rail sequencing controller: enable decode, turn-on and turn-off waits,
  reference ramps, power good, and up/down events on the shared group bus.
  Assumes configuration is static while the rail runs and that the power
  stage follows ramp_ref; comparator and pin inputs are asynchronous.
*/
//
// Overview of operation
// - Rail transmits events only while the transmit-block bit 5 is clear.
// - Up-ordered rail waits for the up event of its stored predecessor.
// - Down-ordered rail waits for the down event of its stored partner.
// - On enable, first rail waits its turn-on delay, then ramps over rise time.
// - Power good only after output stayed above threshold for the delay.
// - Rail queues an up event for the bus the moment its power good asserts.
// - On disable, first rail waits turn-off delay, then ramps down over fall time.
// - Power good drops once the down ramp has completed, or at once on immediate off.
// - Rail broadcasts a down event when its output reaches zero.
// - Immediate-off option skips down ordering and kills the rail at once.
// - Own 5-bit identifier sits in group setup bits 4 to 0.
`timescale 1ns/100ps
module rslc_ctrl
  import rslc_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = MS_NS / CLK_NS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Configuration
  input wire rslc_cfg_t cfg,
  input wire logic op_on,
  // Asynchronous inputs
  input wire logic ctrl_pin,
  input wire logic vout_above_pg,
  // Power stage and status
  output logic [9:0] ramp_ref,
  output logic stage_enable,
  output logic power_good,
  // Group event bus pin
  input wire logic gbus_in,
  output logic gbus_out,
  output logic gbus_oe_n
);
  typedef enum logic [3:0] {
    ST_OFF, ST_WAIT_PREV, ST_ON_WAIT, ST_RISE, ST_PG_WAIT,
    ST_ON, ST_WAIT_NEXT, ST_OFF_WAIT, ST_FALL
  } rslc_st_t;

  localparam int unsigned SUB_CYC = CYC_PER_MS / REF_STEPS;

  rslc_st_t st_r, st_nxt;
  logic ctrl_m_r, ctrl_s_r, pg_m_r, pg_s_r;
  logic [31:0] cyc_r, sub_r;
  logic [15:0] ms_r, step_r;
  logic up_heard_r, dn_heard_r, up_pend_r, dn_pend_r;
  logic on_req, imm_off, tx_block, up_en, dn_en, off_path;
  logic ms_tick, sub_tick, step_tick, tmr_clr, pg_ok;
  logic tx_valid, tx_ready, rx_valid, tx_take;
  rslc_evt_t tx_evt, rx_evt;
  logic [4:0] own_id;

  // Event matches a stored partner id of the wanted kind
  function automatic logic ev_match(input rslc_evt_t ev, input logic kind, input logic [4:0] id);
    ev_match = (ev.kind == kind) && (ev.id == id);
  endfunction : ev_match

  // Decodes the on/off configuration into a run request
  function automatic logic on_request(input logic [7:0] ooc, input logic pin, input logic cmd);
    logic pin_ok;
    logic cmd_ok;
    pin_ok = !ooc[OOC_PIN] || (pin == ooc[OOC_POL]);
    cmd_ok = !ooc[OOC_CMD] || cmd;
    on_request = !ooc[OOC_OBEY] || (pin_ok && cmd_ok);
  endfunction : on_request

  // Pin and comparator synchronisers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_m_r <= 1'b0;
      ctrl_s_r <= 1'b0;
      pg_m_r <= 1'b0;
      pg_s_r <= 1'b0;
    end else begin
      ctrl_m_r <= ctrl_pin;
      ctrl_s_r <= ctrl_m_r;
      pg_m_r <= vout_above_pg;
      pg_s_r <= pg_m_r;
    end
  end

  // Configuration decode
  assign on_req = on_request(cfg.on_off, ctrl_s_r, op_on);
  assign imm_off = cfg.on_off[OOC_IMM];
  assign tx_block = cfg.group_setup[GBS_BLOCK];
  assign own_id = cfg.group_setup[GBS_ID_LO +: ID_W];
  assign up_en = cfg.order_cfg[ORD_UP_EN];
  assign dn_en = cfg.order_cfg[ORD_DN_EN];
  assign off_path = (st_r == ST_RISE) || (st_r == ST_PG_WAIT) || (st_r == ST_ON);

  // Millisecond timer, restarted on every state change and on a threshold dip while waiting for power good
  assign tmr_clr = (st_nxt != st_r) || ((st_r == ST_PG_WAIT) && !pg_s_r);
  assign ms_tick = (cyc_r == CYC_PER_MS - 1);
  always_ff @(posedge clk) begin
    if (!rstn || tmr_clr) begin
      cyc_r <= '0;
      ms_r <= '0;
    end else if (ms_tick) begin
      cyc_r <= '0;
      ms_r <= (ms_r == 16'hffff) ? ms_r : ms_r + 16'h1;
    end else begin
      cyc_r <= cyc_r + 1;
    end
  end

  // Ramp pacing: one code step every ramp_ms sub-ticks spans ramp_ms overall
  assign sub_tick = (sub_r == SUB_CYC - 1);
  assign step_tick = sub_tick && (step_r == ((st_r == ST_FALL) ? cfg.toff_ramp : cfg.ton_ramp));
  always_ff @(posedge clk) begin
    if (!rstn || tmr_clr) begin
      sub_r <= '0;
      step_r <= 16'h1;
    end else if (sub_tick) begin
      sub_r <= '0;
      step_r <= step_tick ? 16'h1 : step_r + 16'h1;
    end else begin
      sub_r <= sub_r + 1;
    end
  end

  // Power good qualification: above threshold for the whole delay
  assign pg_ok = pg_s_r && (ms_r >= cfg.pg_delay);

  // Sequencing state machine
  always_comb begin
    st_nxt = st_r;
    if (off_path && !on_req) begin
      if (imm_off) begin
        st_nxt = ST_OFF;
      end else if (dn_en) begin
        st_nxt = ST_WAIT_NEXT;
      end else begin
        st_nxt = ST_OFF_WAIT;
      end
    end else begin
      case (st_r)
        ST_OFF: begin
          if (on_req) begin
            st_nxt = up_en ? ST_WAIT_PREV : ST_ON_WAIT;
          end
        end
        ST_WAIT_PREV: begin
          if (!on_req) begin
            st_nxt = ST_OFF;
          end else if (up_heard_r) begin
            st_nxt = ST_ON_WAIT;
          end
        end
        ST_ON_WAIT: begin
          if (!on_req) begin
            st_nxt = ST_OFF;
          end else if (ms_r >= cfg.ton_wait) begin
            st_nxt = ST_RISE;
          end
        end
        ST_RISE: begin
          if (ramp_ref == REF_FULL) begin
            st_nxt = ST_PG_WAIT;
          end
        end
        ST_PG_WAIT: begin
          if (pg_ok) begin
            st_nxt = ST_ON;
          end
        end
        ST_ON: st_nxt = ST_ON;
        ST_WAIT_NEXT: begin
          if (dn_heard_r) begin
            st_nxt = ST_OFF_WAIT;
          end
        end
        ST_OFF_WAIT: begin
          if (ms_r >= cfg.toff_wait) begin
            st_nxt = ST_FALL;
          end
        end
        ST_FALL: begin
          if (ramp_ref == REF_ZERO) begin
            st_nxt = ST_OFF;
          end
        end
        default: st_nxt = ST_OFF;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_r <= ST_OFF;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Reference ramp; a zero ramp time moves one code per cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ramp_ref <= REF_ZERO;
    end else if (st_nxt == ST_OFF) begin
      ramp_ref <= REF_ZERO;
    end else if ((st_r == ST_RISE) && (step_tick || cfg.ton_ramp == 16'h0) && ramp_ref != REF_FULL) begin
      ramp_ref <= ramp_ref + 10'h001;
    end else if ((st_r == ST_FALL) && (step_tick || cfg.toff_ramp == 16'h0) && ramp_ref != REF_ZERO) begin
      ramp_ref <= ramp_ref - 10'h001;
    end
  end

  // Power stage runs from the start of the rise until the rail is off
  always_ff @(posedge clk) begin
    if (!rstn) begin
      stage_enable <= 1'b0;
    end else begin
      stage_enable <= !(st_nxt inside {ST_OFF, ST_WAIT_PREV, ST_ON_WAIT});
    end
  end

  // Power good holds through the down wait and fall, dropping with the ramp end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      power_good <= 1'b0;
    end else if (st_nxt == ST_ON && st_r == ST_PG_WAIT) begin
      power_good <= 1'b1;
    end else if (st_nxt == ST_OFF) begin
      power_good <= 1'b0;
    end
  end

  // Partner events heard; a hit in the clearing cycle still counts
  always_ff @(posedge clk) begin
    if (!rstn) begin
      up_heard_r <= 1'b0;
      dn_heard_r <= 1'b0;
    end else begin
      if (rx_valid && up_en && ev_match(rx_evt, EVT_UP, cfg.order_cfg[ORD_PREV_LO +: ID_W])) begin
        up_heard_r <= 1'b1;
      end else if (!on_req || st_nxt == ST_ON_WAIT) begin
        up_heard_r <= 1'b0;
      end
      if (rx_valid && dn_en && ev_match(rx_evt, EVT_DN, cfg.order_cfg[ORD_NEXT_LO +: ID_W])) begin
        dn_heard_r <= 1'b1;
      end else if (on_req || st_nxt == ST_OFF_WAIT) begin
        dn_heard_r <= 1'b0;
      end
    end
  end

  // Outgoing events wait here until the bus is free; up has priority
  assign tx_valid = !tx_block && (up_pend_r || dn_pend_r);
  assign tx_evt = '{id: own_id, kind: up_pend_r ? EVT_UP : EVT_DN};
  assign tx_take = tx_valid && tx_ready;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      up_pend_r <= 1'b0;
      dn_pend_r <= 1'b0;
    end else begin
      if (!tx_block && st_r == ST_PG_WAIT && st_nxt == ST_ON) begin
        up_pend_r <= 1'b1;
      end else if (tx_take && up_pend_r) begin
        up_pend_r <= 1'b0;
      end
      if (!tx_block && st_r != ST_OFF && stage_enable && st_nxt == ST_OFF) begin
        dn_pend_r <= 1'b1;
      end else if (tx_take && !up_pend_r) begin
        dn_pend_r <= 1'b0;
      end
    end
  end

  // Bus transceiver
  rslc_gbus_phy u_phy (
    .clk(clk),
    .rstn(rstn),
    .tx_valid(tx_valid),
    .tx_evt(tx_evt),
    .tx_ready(tx_ready),
    .rx_valid(rx_valid),
    .rx_evt(rx_evt),
    .line_in(gbus_in),
    .line_out(gbus_out),
    .line_oe_n(gbus_oe_n)
  );

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  property p_tx_block;
    tx_block |-> gbus_oe_n;
  endproperty
  a_tx_block: assert property (p_tx_block) else $error("bus pulled while transmit blocked");

  property p_wait_prev;
    (st_r == ST_WAIT_PREV) && !up_heard_r && on_req |=> (st_r == ST_WAIT_PREV);
  endproperty
  a_wait_prev: assert property (p_wait_prev) else $error("left predecessor wait without event");

  property p_first_up;
    (st_r == ST_OFF) && on_req && !up_en |=> (st_r == ST_ON_WAIT) && (ramp_ref == REF_ZERO);
  endproperty
  a_first_up: assert property (p_first_up) else $error("first rail did not start turn-on wait");

  property p_rise_up;
    // Widened compare so the top code cannot wrap the allowed step
    (st_r == ST_RISE) && on_req |=> (ramp_ref == $past(ramp_ref)) ||
      ({1'b0, ramp_ref} == {1'b0, $past(ramp_ref)} + 11'h001);
  endproperty
  a_rise_up: assert property (p_rise_up) else $error("rise ramp not monotonic by one code");

  property p_pg_cause;
    $rose(power_good) |-> $past(st_r == ST_PG_WAIT) && $past(pg_s_r) && ($past(ms_r) >= cfg.pg_delay);
  endproperty
  a_pg_cause: assert property (p_pg_cause) else $error("power good without qualified delay");

  property p_up_evt;
    $rose(power_good) && !tx_block |-> up_pend_r;
  endproperty
  a_up_evt: assert property (p_up_evt) else $error("no up event with power good");

  property p_first_dn;
    (st_r == ST_ON) && !on_req && !dn_en && !imm_off |=> (st_r == ST_OFF_WAIT) && power_good;
  endproperty
  a_first_dn: assert property (p_first_dn) else $error("first down rail skipped turn-off wait");

  property p_pg_drop;
    $fell(power_good) |-> (ramp_ref == REF_ZERO) && ($past(st_r) == ST_FALL || $past(imm_off));
  endproperty
  a_pg_drop: assert property (p_pg_drop) else $error("power good fell before ramp end");

  property p_dn_evt;
    (st_r == ST_FALL) && (st_nxt == ST_OFF) && !tx_block |=> dn_pend_r && (ramp_ref == REF_ZERO);
  endproperty
  a_dn_evt: assert property (p_dn_evt) else $error("no down event at zero output");

  property p_imm_off;
    off_path && !on_req && imm_off |=> (st_r == ST_OFF) && (ramp_ref == REF_ZERO) && !power_good;
  endproperty
  a_imm_off: assert property (p_imm_off) else $error("immediate off did not kill the rail");

  property p_own_id;
    tx_valid |-> (tx_evt.id == cfg.group_setup[4:0]);
  endproperty
  a_own_id: assert property (p_own_id) else $error("event carries wrong sender id");

  property p_match;
    (st_r == ST_WAIT_NEXT) ##1 (st_r == ST_OFF_WAIT) |-> $past(dn_heard_r) && dn_en;
  endproperty
  a_match: assert property (p_match) else $error("down wait ended without partner event");

  c_reach_on: cover property ($rose(power_good));
  c_full_down: cover property ((st_r == ST_FALL) ##1 (st_r == ST_OFF));
  c_imm_kill: cover property (off_path && !on_req && imm_off);
  c_follow_up: cover property ((st_r == ST_WAIT_PREV) ##1 (st_r == ST_ON_WAIT));
endmodule : rslc_ctrl

//--- hw/rslc_gbus_phy.sv
/*
  One-wire group event bus transceiver: sends and receives short event frames.
  Assumes an external pull-up; the line is only ever pulled low, never driven high.
*/
`timescale 1ns/100ps
module rslc_gbus_phy
  import rslc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Transmit request
  input wire logic tx_valid,
  input wire rslc_evt_t tx_evt,
  output logic tx_ready,
  // Received event
  output logic rx_valid,
  output rslc_evt_t rx_evt,
  // Bus pin
  input wire logic line_in,
  output logic line_out,
  output logic line_oe_n
);
  typedef enum logic [1:0] {PH_IDLE, PH_TX, PH_RX} rslc_ph_t;
  rslc_ph_t ph_r;
  logic line_m_r, line_s_r, line_p_r;
  logic [31:0] cnt_r;
  logic [2:0] bit_r;
  logic [6:0] sh_r;

  // Two-stage synchroniser, then an edge register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      line_m_r <= 1'b1;
      line_s_r <= 1'b1;
      line_p_r <= 1'b1;
    end else begin
      line_m_r <= line_in;
      line_s_r <= line_m_r;
      line_p_r <= line_s_r;
    end
  end

  // Only start a frame on an idle, released line
  assign tx_ready = (ph_r == PH_IDLE) && line_s_r && line_p_r;
  assign line_out = 1'b0;

  // Frame engine; wired-AND collisions are not arbitrated
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ph_r <= PH_IDLE;
      cnt_r <= '0;
      bit_r <= '0;
      sh_r <= '0;
      line_oe_n <= 1'b1;
      rx_valid <= 1'b0;
      rx_evt <= '0;
    end else begin
      rx_valid <= 1'b0;
      case (ph_r)
        PH_IDLE: begin
          bit_r <= '0;
          if (tx_valid && tx_ready) begin
            ph_r <= PH_TX;
            sh_r <= {tx_evt, 1'b0};
            cnt_r <= BIT_CYC - 1;
            line_oe_n <= 1'b0; // Start bit
          end else if (line_p_r && !line_s_r) begin
            ph_r <= PH_RX;
            cnt_r <= BIT_CYC + BIT_CYC / 2 - 1; // Middle of first data bit
          end
        end
        PH_TX: begin
          if (cnt_r != 0) begin
            cnt_r <= cnt_r - 1;
          end else if (bit_r == FRAME_LAST) begin
            ph_r <= PH_IDLE;
            line_oe_n <= 1'b1;
          end else begin
            bit_r <= bit_r + 3'h1;
            sh_r <= {1'b1, sh_r[6:1]};
            line_oe_n <= sh_r[1];
            cnt_r <= BIT_CYC - 1;
          end
        end
        PH_RX: begin
          if (cnt_r != 0) begin
            cnt_r <= cnt_r - 1;
          end else begin
            sh_r <= {line_s_r, sh_r[6:1]};
            bit_r <= bit_r + 3'h1;
            cnt_r <= BIT_CYC - 1;
            if (bit_r == FRAME_LAST - 3'h1) begin
              ph_r <= PH_IDLE;
              rx_valid <= 1'b1;
              rx_evt <= {line_s_r, sh_r[6:2]};
            end
          end
        end
        default: ph_r <= PH_IDLE;
      endcase
    end
  end
endmodule : rslc_gbus_phy

//--- hw/rslc_pkg.sv
/*
  Shared constants and carrier types of the rail sequencing controller.
  Assumes a 250 MHz core clock and a one-wire open-drain group event bus.
*/
package rslc_pkg;
  // Clock and time bases
  localparam int unsigned CLK_NS = 4;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned CYC_MS = MS_NS / CLK_NS;
  localparam int unsigned BIT_NS = 4000;
  localparam int unsigned BIT_CYC = BIT_NS / CLK_NS;
  localparam int unsigned REF_STEPS = 1024;
  // Ramp reference code
  localparam int unsigned REF_W = 10;
  localparam logic [9:0] REF_ZERO = 10'h000;
  localparam logic [9:0] REF_FULL = 10'h3ff;
  // On/off configuration fields
  localparam int unsigned OOC_IMM = 0;
  localparam int unsigned OOC_POL = 1;
  localparam int unsigned OOC_PIN = 2;
  localparam int unsigned OOC_CMD = 3;
  localparam int unsigned OOC_OBEY = 4;
  // Group setup fields
  localparam int unsigned GBS_BLOCK = 5;
  localparam int unsigned GBS_ID_LO = 0;
  // Order configuration fields
  localparam int unsigned ORD_UP_EN = 15;
  localparam int unsigned ORD_PREV_LO = 8;
  localparam int unsigned ORD_DN_EN = 7;
  localparam int unsigned ORD_NEXT_LO = 0;
  localparam int unsigned ID_W = 5;
  // Frame layout: start bit then kind and id, lsb first
  localparam logic [2:0] FRAME_LAST = 3'h6;
  localparam logic EVT_UP = 1'b0;
  localparam logic EVT_DN = 1'b1;

  typedef struct packed {
    logic [7:0] on_off;
    logic [15:0] group_setup;
    logic [15:0] order_cfg;
    logic [15:0] ton_wait;
    logic [15:0] ton_ramp;
    logic [15:0] toff_wait;
    logic [15:0] toff_ramp;
    logic [15:0] pg_delay;
  } rslc_cfg_t;

  typedef struct packed {
    logic [4:0] id;
    logic kind;
  } rslc_evt_t;
endpackage : rslc_pkg

//--- tb/rslc_peer_model.sv
/*
  Peer rail model on the shared group event bus: sends event frames on request, decodes frames it hears.
  Assumes the bench resolves the open-drain wire with a pull-up and feeds the level back on line.
*/
`timescale 1ns/100ps
module rslc_peer_model
  import rslc_pkg::*;
(
  // Clock
  input wire logic clk,
  // Send request
  input wire logic send,
  input wire rslc_evt_t send_evt,
  output logic busy,
  // Bus wire
  input wire logic line,
  output logic pull,
  // Last decoded event
  output rslc_evt_t got_evt,
  output int got_cnt
);
  logic [6:0] frame;
  logic [5:0] sh;

  // Sender: start bit, kind, then id lsb first; only ever pulls low, never drives high
  initial begin
    pull = 1'b0;
    busy = 1'b0;
    forever begin
      do @(posedge clk); while (!send);
      busy <= 1'b1;
      frame = {send_evt, 1'b0};
      for (int i = 0; i < 7; i++) begin
        pull <= ~frame[i];
        repeat (BIT_CYC) @(posedge clk);
      end
      pull <= 1'b0;
      busy <= 1'b0;
    end
  end

  // Receiver: samples mid-bit; skips own frames, as a real rail would
  initial begin
    got_evt = '0;
    got_cnt = 0;
    forever begin
      @(negedge line);
      if (!busy) begin
        repeat (BIT_CYC + BIT_CYC / 2) @(posedge clk);
        for (int i = 0; i < 6; i++) begin
          sh[i] = line;
          if (i < 5) repeat (BIT_CYC) @(posedge clk);
        end
        got_evt = sh;
        got_cnt++;
      end
    end
  end
endmodule : rslc_peer_model

//--- tb/tb_rslc_ctrl.sv
/*
  Self-checking bench for the rail sequencing controller with one peer rail on the group bus.
  Assumes CYC_PER_MS of 1024, so one ms is 1024 cycles; the power stage is modelled by the ramp code.
*/
`timescale 1ns/100ps
module tb_rslc_ctrl
  import rslc_pkg::*;
;
  localparam int MS = 1024;
  localparam logic [4:0] OWN_ID = 5'h05;
  localparam logic [4:0] PEER_ID = 5'h03; // Distinct ids on one bus
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic op_on = 1'b0;
  logic ctrl_pin = 1'b0;
  logic peer_send = 1'b0;
  rslc_cfg_t cfg;
  rslc_evt_t peer_evt, got_evt;
  logic [9:0] ramp_ref;
  logic vout_above_pg, stage_enable, power_good, gbus_out, gbus_oe_n, gbus, peer_pull, peer_busy;
  int got_cnt, cnt0, low_cyc;
  int failures = 0;
  int tests_run = 0;

  // 250 MHz core clock
  always #2 clk = ~clk;
  // Stage model: output above threshold once the ramp tops out
  assign vout_above_pg = (ramp_ref == REF_FULL);
  // Open-drain wire with pull-up
  assign gbus = (gbus_oe_n ? 1'b1 : gbus_out) & ~peer_pull;
  // Cycles the rail spends pulling the bus
  always @(posedge clk) if (!gbus_oe_n) low_cyc++;

  rslc_ctrl #(.CYC_PER_MS(MS)) uut (.clk(clk), .rstn(rstn), .cfg(cfg), .op_on(op_on), .ctrl_pin(ctrl_pin),
    .vout_above_pg(vout_above_pg), .ramp_ref(ramp_ref), .stage_enable(stage_enable), .power_good(power_good),
    .gbus_in(gbus), .gbus_out(gbus_out), .gbus_oe_n(gbus_oe_n));
  rslc_peer_model peer (.clk(clk), .send(peer_send), .send_evt(peer_evt), .busy(peer_busy), .line(gbus),
    .pull(peer_pull), .got_evt(got_evt), .got_cnt(got_cnt));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic chk_rng(input string name, input int n, input int lo, input int hi);
    tests_run++;
    if (n < lo || n > hi) begin
      failures++;
      $display("mismatch %s expected %0d..%0d seen %0d", name, lo, hi, n);
    end
  endtask : chk_rng

  function automatic logic pick(input int k);
    case (k)
      0: return stage_enable;
      1: return power_good;
      2: return ramp_ref == REF_FULL;
      3: return gbus_oe_n;
      4: return ramp_ref == REF_ZERO;
      default: return got_cnt != cnt0;
    endcase
  endfunction : pick

  // Bounded wait on a watched condition; a timeout ends the run
  task automatic wait_for(input int k, input logic v, input int lim, output int n);
    n = 0;
    while (pick(k) !== v) begin
      @(negedge clk);
      n++;
      if (n > lim) begin
        failures++;
        $display("mismatch wait_%0d expected %0b seen timeout", k, v);
        report_and_stop();
      end
    end
  endtask : wait_for

  task automatic do_reset(input logic [7:0] oo, input logic [15:0] gs, input logic [15:0] ord);
    rstn = 1'b0;
    ctrl_pin = 1'b0;
    op_on = 1'b0;
    cfg.on_off = oo;
    cfg.group_setup = gs;
    cfg.order_cfg = ord;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
  endtask : do_reset

  task automatic peer_tx(input logic kind, input logic [4:0] id);
    peer_evt = {id, kind};
    peer_send = 1'b1;
    @(negedge clk);
    peer_send = 1'b0;
  endtask : peer_tx

  // Rail frame must start promptly and carry our id and the kind
  task automatic expect_evt(input logic kind);
    int n;
    cnt0 = got_cnt;
    wait_for(3, 1'b0, 20, n);
    wait_for(5, 1'b1, 8000, n);
    check("evt", got_evt, {OWN_ID, kind});
  endtask : expect_evt

  task automatic power_up(input int lo, input int hi, input logic tx);
    int n;
    wait_for(0, 1'b1, hi, n);
    chk_rng("turn_on_wait", n, lo, hi);
    wait_for(2, 1'b1, 1100, n);
    chk_rng("turn_on_ramp", n, 1000, 1050);
    check("pg_early", power_good, 1'b0);
    wait_for(1, 1'b1, 1100, n);
    chk_rng("pg_delay", n, MS, MS + 10);
    if (tx) expect_evt(EVT_UP);
  endtask : power_up

  task automatic power_down(input int lo, input int hi, input logic tx);
    int n;
    wait_for(2, 1'b0, hi, n);
    chk_rng("turn_off_wait", n, lo, hi);
    check("pg_hold", power_good, 1'b1);
    wait_for(4, 1'b1, 1100, n);
    chk_rng("turn_off_ramp", n, 1000, 1050);
    wait_for(1, 1'b0, 3, n);
    if (tx) expect_evt(EVT_DN);
    check("stage_off", stage_enable, 1'b0);
  endtask : power_down

  // First rail under pin control, full up and down
  task automatic t_lead_pin();
    do_reset(8'h16, {11'h0, OWN_ID}, 16'h0000);
    check("rst_ramp", ramp_ref, REF_ZERO);
    check("rst_pg", power_good, 1'b0);
    check("rst_oe", gbus_oe_n, 1'b1);
    check("rst_od", gbus_out, 1'b0);
    ctrl_pin = 1'b1;
    power_up(MS, MS + 10, 1'b1);
    ctrl_pin = 1'b0;
    power_down(MS, MS + 10, 1'b1);
    $display("test lead_pin done");
  endtask : t_lead_pin

  // Follower: waits for the peer's up event, and for its down event before turning off
  task automatic t_follow();
    do_reset(8'h16, {11'h0, OWN_ID}, {1'b1, 2'b00, PEER_ID, 1'b1, 2'b00, PEER_ID});
    ctrl_pin = 1'b1;
    peer_tx(EVT_UP, 5'h04);
    repeat (8000) @(negedge clk);
    check("stray_id", stage_enable, 1'b0);
    peer_tx(EVT_UP, PEER_ID);
    power_up(7400, 7600, 1'b1);
    ctrl_pin = 1'b0;
    repeat (2000) @(negedge clk);
    check("wait_next", ramp_ref, REF_FULL);
    peer_tx(EVT_DN, PEER_ID);
    power_down(7400, 7600, 1'b1);
    $display("test follow done");
  endtask : t_follow

  // Immediate off skips the turn-off wait and ramp
  task automatic t_imm();
    int n;
    do_reset(8'h17, {11'h0, OWN_ID}, 16'h0000);
    ctrl_pin = 1'b1;
    power_up(MS, MS + 10, 1'b1);
    // Let the up frame end, so the down frame start is really timed
    wait_for(3, 1'b1, 1100, n);
    ctrl_pin = 1'b0;
    wait_for(1, 1'b0, 8, n);
    check("imm_ramp", ramp_ref, REF_ZERO);
    expect_evt(EVT_DN);
    $display("test imm done");
  endtask : t_imm

  // Command-driven rail with transmit blocked: pin ignored, bus never pulled
  task automatic t_block();
    int low0;
    do_reset(8'h1a, {10'h0, 1'b1, OWN_ID}, 16'h0000);
    low0 = low_cyc;
    ctrl_pin = 1'b1;
    repeat (1200) @(negedge clk);
    check("pin_ignored", stage_enable, 1'b0);
    op_on = 1'b1;
    power_up(MS, MS + 10, 1'b0);
    op_on = 1'b0;
    power_down(MS, MS + 10, 1'b0);
    repeat (50) @(negedge clk);
    check("blocked", low_cyc, low0);
    $display("test block done");
  endtask : t_block

  // Main sequence
  initial begin
    // Precise timing mode is not modelled; every member is taken to run with it off
    cfg = '0;
    cfg.ton_wait = 16'h0001;
    cfg.ton_ramp = 16'h0001;
    cfg.toff_wait = 16'h0001;
    cfg.toff_ramp = 16'h0001;
    cfg.pg_delay = 16'h0001;
    peer_evt = '0;
    t_lead_pin();
    t_follow();
    t_imm();
    t_block();
    report_and_stop();
  end
endmodule : tb_rslc_ctrl
